// file: fdm_modulator.v
// Purpose: Frame-rate duty ratio modulator for the pixel output path
// Assumes: vsync and the pixel stream come from logic on clk
// Notes: Contract list below; AXI4-Lite slave holds duties and mode
//
// Contract
// - Modulators step once per frame at the vsync rising edge; the code steps only while run is set.
// - Same pseudo level gives the same output everywhere within a frame.
// - Active frames are spread evenly, never one contiguous block.
// - Modulation period is a power of two frames.
// - Accumulator adds duty each frame; carry out means active.
// - Duty resolves to six bits, a period of 64 frames.
// - Modulation only for 4-bit grey and RGB222 mappings.
// - Grey 0 is constant off, 15 constant on, 1..14 pseudo.
// - Grey value n from 1 to 14 outputs modulator n-1.
// - Each of the fourteen duties is written independently by software.
// - Each modulator presents a single bit at any moment.
// - RGB mode splits the pixel into three 2-bit channels.
// - Channel 0 off, 3 on, 1 and 2 use dedicated modulators.
// - Red uses modulators 4,5; green 2,3; blue 0,1.
`default_nettype none
`include "fdm_regs.vh"

module fdm_fifo #(
  parameter WIDTH = 6,
  parameter DEPTH = `FDM_FIFO_DEPTH,
  parameter AW = `FDM_FIFO_AW
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;
  localparam [AW:0] ONE = 1;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  wire push;
  wire pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + ONE;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - ONE;
    end
  end

  // Ready is registered so the top output comes from a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL);
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule // fdm_fifo

module fdm_modulator (
  // Clock and reset
  input wire clk,
  input wire rst,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Frame timing
  input wire vsync,
  // Intermediate pixel stream in
  input wire pix_valid,
  output wire pix_ready,
  input wire [5:0] pix_data,
  // Physical pixel stream out
  output reg phys_valid,
  input wire phys_ready,
  output reg [2:0] phys_data
);
  localparam NM = `FDM_NMOD;
  localparam DW = `FDM_DUTY_W;

  // Register file
  reg run_r;
  reg [1:0] mode_r;
  reg [DW-1:0] duty_r [0:NM-1];
  reg [DW-1:0] frame_r;
  reg vsync_d_r;
  wire frame_adv;
  wire [NM-1:0] mod_on;

  // Bus bookkeeping
  reg aw_got_r;
  reg w_got_r;
  reg [11:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_got_nxt;
  reg w_got_nxt;
  reg bvalid_nxt;
  reg rvalid_nxt;
  wire aw_hs;
  wire w_hs;
  wire ar_hs;
  wire do_write;

  // Stream path
  wire fifo_valid;
  wire [5:0] fifo_data;
  wire pop;
  integer k;

  // Decode: 1 if the address names a register
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `FDM_OFF_CTRL) || (a == `FDM_OFF_STATUS) ||
        ((a >= `FDM_OFF_DUTY0) && (a <= `FDM_OFF_DUTY13) && (a[1:0] == 2'h0));
    end
  endfunction

  // Decode: duty slot index of a duty address
  function [3:0] duty_idx;
    input [11:0] a;
    reg [11:0] d;
    begin
      d = a - `FDM_OFF_DUTY0;
      duty_idx = d[5:2];
    end
  endfunction

  function is_duty;
    input [11:0] a;
    begin
      is_duty = (a >= `FDM_OFF_DUTY0) && (a <= `FDM_OFF_DUTY13) && (a[1:0] == 2'h0);
    end
  endfunction

  // One 2-bit channel to one physical bit
  function map_ch;
    input [1:0] v;
    input lo;
    input hi;
    begin
      case (v)
        2'h0: map_ch = 1'b0;
        2'h1: map_ch = lo;
        2'h2: map_ch = hi;
        default: map_ch = 1'b1;
      endcase
    end
  endfunction

  // Grey value to physical bit
  function map_grey;
    input [3:0] v;
    input [NM-1:0] on;
    reg [3:0] idx;
    begin
      idx = v - 4'h1;
      if (v == 4'h0) begin
        map_grey = 1'b0;
      end else if (v == 4'hf) begin
        map_grey = 1'b1;
      end else begin
        map_grey = on[idx];
      end
    end
  endfunction

  // Mapping of one intermediate pixel for the current frame
  function [2:0] map_pix;
    input [1:0] mode;
    input [5:0] p;
    input [NM-1:0] on;
    begin
      case (mode)
        `FDM_MODE_GREY4: begin
          map_pix = {2'h0, map_grey(p[3:0], on)};
        end
        `FDM_MODE_RGB222: begin
          map_pix[2] = map_ch(p[5:4], on[4], on[5]);
          map_pix[1] = map_ch(p[3:2], on[2], on[3]);
          map_pix[0] = map_ch(p[1:0], on[0], on[1]);
        end
        default: begin
          // No modulation: low bits pass unchanged
          map_pix = p[2:0];
        end
      endcase
    end
  endfunction

  // Frame step on vsync rising edge, only while running
  assign frame_adv = vsync & ~vsync_d_r & run_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vsync_d_r <= 1'b0;
      frame_r <= {DW{1'b0}};
    end else begin
      vsync_d_r <= vsync;
      if (frame_adv) begin
        // Six bits wrap at 64 frames
        frame_r <= frame_r + 1'b1;
      end
    end
  end

  // Bresenham step per modulator; the carry is the active decision
  genvar g;
  generate
    for (g = 0; g < NM; g = g + 1) begin : gen_mod
      reg [DW-1:0] acc_r;
      reg on_r;
      wire [DW:0] sum;
      assign sum = {1'b0, acc_r} + {1'b0, duty_r[g]};
      assign mod_on[g] = on_r;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          acc_r <= {DW{1'b0}};
          on_r <= 1'b0;
        end else if (frame_adv) begin
          // Carries are spread evenly over the period
          on_r <= sum[DW];
          // Restart each period so output is fixed by counter and duty
          if (frame_r == `FDM_FRAME_LAST) begin
            acc_r <= {DW{1'b0}};
          end else begin
            acc_r <= sum[DW-1:0];
          end
        end
      end
    end
  endgenerate

  // Pixel buffer ahead of the mapping stage
  fdm_fifo #(
    .WIDTH(6),
    .DEPTH(`FDM_FIFO_DEPTH),
    .AW(`FDM_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  assign pop = fifo_valid & (~phys_valid | phys_ready);

  // All pixels of a frame see one shared modulator vector
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phys_valid <= 1'b0;
      phys_data <= 3'h0;
    end else if (pop) begin
      phys_valid <= 1'b1;
      phys_data <= map_pix(mode_r, fifo_data, mod_on);
    end else if (phys_ready) begin
      phys_valid <= 1'b0;
    end
  end

  // Write channel: address and data taken in either order
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid;

  always @* begin
    aw_got_nxt = aw_got_r | aw_hs;
    w_got_nxt = w_got_r | w_hs;
    bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end
    rvalid_nxt = (s_axi_rvalid & ~s_axi_rready) | ar_hs;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FDM_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `FDM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      // One write and one read outstanding at a time
      s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_got_nxt & ~bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      if (aw_hs) begin
        waddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= addr_ok(waddr_r) ? `FDM_RESP_OKAY : `FDM_RESP_SLVERR;
      end
      if (ar_hs) begin
        s_axi_rresp <= addr_ok(s_axi_araddr) ? `FDM_RESP_OKAY : `FDM_RESP_SLVERR;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr == `FDM_OFF_CTRL) begin
          s_axi_rdata[`FDM_CTRL_RUN] <= run_r;
          s_axi_rdata[`FDM_CTRL_MODE_HI:`FDM_CTRL_MODE_LO] <= mode_r;
        end else if (s_axi_araddr == `FDM_OFF_STATUS) begin
          s_axi_rdata[`FDM_STAT_FRAME_LO+DW-1:`FDM_STAT_FRAME_LO] <= frame_r;
          s_axi_rdata[`FDM_STAT_MOD_LO+NM-1:`FDM_STAT_MOD_LO] <= mod_on;
        end else if (is_duty(s_axi_araddr)) begin
          s_axi_rdata[DW-1:0] <= duty_r[duty_idx(s_axi_araddr)];
        end
      end
    end
  end

  // Software state; only byte lane 0 carries fields
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r <= `FDM_RUN_RST;
      mode_r <= `FDM_MODE_GREY4;
      for (k = 0; k < NM; k = k + 1) begin
        duty_r[k] <= `FDM_DUTY_RST;
      end
    end else if (do_write & wstrb_r[0]) begin
      if (waddr_r == `FDM_OFF_CTRL) begin
        run_r <= wdata_r[`FDM_CTRL_RUN];
        mode_r <= wdata_r[`FDM_CTRL_MODE_HI:`FDM_CTRL_MODE_LO];
      end else if (is_duty(waddr_r)) begin
        duty_r[duty_idx(waddr_r)] <= wdata_r[DW-1:0];
      end
    end
  end
endmodule // fdm_modulator
`default_nettype wire

// file: fdm_regs.vh
// Purpose: Constants for the frame duty ratio modulator
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: One aligned word per register
`ifndef FDM_REGS_VH
`define FDM_REGS_VH

// Register byte offsets
`define FDM_OFF_CTRL 12'h000
`define FDM_OFF_STATUS 12'h004
`define FDM_OFF_DUTY0 12'h010
`define FDM_OFF_DUTY13 12'h044

// Control fields
`define FDM_CTRL_RUN 0
`define FDM_CTRL_MODE_LO 1
`define FDM_CTRL_MODE_HI 2
`define FDM_CTRL_RST 3'h3
`define FDM_RUN_RST 1'b1

// Colour mappings
`define FDM_MODE_BYPASS 2'h0
`define FDM_MODE_GREY4 2'h1
`define FDM_MODE_RGB222 2'h2

// Status fields
`define FDM_STAT_FRAME_LO 0
`define FDM_STAT_MOD_LO 8

// Modulators
`define FDM_NMOD 14
`define FDM_DUTY_W 6
`define FDM_DUTY_RST 6'h20
`define FDM_FRAME_LAST 6'h3f

// Bus responses
`define FDM_RESP_OKAY 2'h0
`define FDM_RESP_SLVERR 2'h2

// Stream buffer
`define FDM_FIFO_DEPTH 4
`define FDM_FIFO_AW 2

`endif

// file: fdm_checker.sv
// Purpose: Port-level protocol checks for the duty modulator
// Assumes: One clock, rst async active high
// Notes: Bound from the bench top file
`default_nettype none
module fdm_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pixel streams
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic phys_valid,
  input wire logic phys_ready,
  input wire logic [2:0] phys_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_phys_stands: assert property (phys_valid && !phys_ready |=> phys_valid
    && $stable(phys_data)) else $error("pixel dropped while stalled");
  a_pix_reach: assert property (pix_valid && pix_ready |-> ##[1:8] phys_valid)
    else $error("pixel never offered");
endmodule // fdm_checker
`default_nettype wire

// file: fdm_panel.sv
// Purpose: Display panel model taking physical pixels
// Assumes: Same clock as the modulator
// Notes: slow makes it stall on three cycles of four on average
`default_nettype none
module fdm_panel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control and stream
  input wire logic slow,
  input wire logic phys_valid,
  output var logic phys_ready
);
  integer seed = 32'hcbff8cf9;
  always @(posedge clk or posedge rst) begin
    if (rst) phys_ready <= 1'b0;
    else phys_ready <= !slow || (($random(seed) & 3) == 0);
  end
endmodule // fdm_panel
`default_nettype wire

// file: tb_frame_duty_ratio_modulator.sv
// Purpose: Self-checking bench for the duty modulator
// Assumes: Modulator state changes only between frames of pixels
// Notes: Reference model mirrors the per-frame accumulators
`default_nettype none
module tb_frame_duty_ratio_modulator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, vsync = 0, slow = 0, pix_valid = 0, phys_ready;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [5:0] pix_data = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire pix_ready, phys_valid;
  wire [2:0] phys_data;
  logic [5:0] duty [14], acc [14];
  logic [13:0] on = 0;
  logic [5:0] frame = 0;
  logic [1:0] mode = 1;
  logic run = 1;
  logic [2:0] q [$];
  int num_errors = 0, compares = 0, cyc = 0;
  integer seed = 32'hcbff8cf9;
  fdm_modulator u_fdm_modulator (.*);
  fdm_panel u_fdm_panel (.*);
  always #5 clk = ~clk;
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [3:0] st, input [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1;
    @(posedge clk);
    s_axi_bready <= 0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1;
    @(posedge clk);
    s_axi_rready <= 0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask
  function logic ch(input [1:0] v, input lo, input hi);
    ch = v == 0 ? 1'b0 : v == 3 ? 1'b1 : v == 1 ? lo : hi;
  endfunction
  function [2:0] expv(input [5:0] v);
    case (mode)
      2'h1: expv = {2'h0, v[3:0] == 0 ? 1'b0 : v[3:0] == 15 ? 1'b1 :
        on[v[3:0] - 4'h1]};
      2'h2: expv = {ch(v[5:4], on[4], on[5]), ch(v[3:2], on[2], on[3]),
        ch(v[1:0], on[0], on[1])};
      default: expv = v[2:0];
    endcase
  endfunction
  // Pixels go only after the step has landed, so a whole frame shares one state
  task frames(input int nf, input bit rnd);
    for (int f = 0; f < nf; f++) begin
      slow <= f[1];
      @(posedge clk);
      vsync <= 1;
      @(posedge clk);
      vsync <= 0;
      if (run) begin
        for (int n = 0; n < 14; n++) begin
          {on[n], acc[n]} = acc[n] + duty[n];
          if (frame == 6'h3f) acc[n] = 0;
        end
        frame = frame + 1;
      end
      repeat (2) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
        pix_data <= rnd ? 6'($random(seed)) : 6'(i);
        pix_valid <= 1;
        do @(posedge clk); while (!pix_ready);
        q.push_back(expv(pix_data));
      end
      pix_valid <= 0;
      while (q.size() != 0) @(posedge clk);
      if (f % 16 == 0) rd(12'h004, {10'h0, on, 2'h0, frame}, 0);
    end
  endtask
  always @(posedge clk) begin
    if (!rst && phys_valid && phys_ready) begin
      if (q.size() != 0) chk(phys_data, q.pop_front());
      else chk(1, 0);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    for (int n = 0; n < 14; n++) acc[n] = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(12'h000, 32'h3, 0);
    rd(12'h044, 32'h20, 0);
    rd(12'h048, 0, 2);
    wr(12'h048, 1, 4'h1, 2);
    for (int n = 0; n < 14; n++) begin
      duty[n] = n == 0 ? 6'h0 : n == 13 ? 6'h3f : 6'($random(seed));
      wr(12'h010 + 12'(4 * n), {26'h0, duty[n]}, 4'h1, 0);
    end
    wr(12'h010, 32'h3f, 4'h0, 0);
    rd(12'h010, 0, 0);
    $display("test registers done");
    frames(70, 0);
    $display("test grey done");
    mode = 2;
    wr(12'h000, 32'h5, 4'h1, 0);
    frames(10, 1);
    $display("test rgb done");
    mode = 0;
    wr(12'h000, 32'h1, 4'h1, 0);
    frames(2, 1);
    mode = 3;
    wr(12'h000, 32'h7, 4'h1, 0);
    frames(2, 1);
    run = 0;
    mode = 1;
    wr(12'h000, 32'h2, 4'h1, 0);
    frames(3, 0);
    $display("test bypass and hold done");
    give_verdict;
  end
endmodule // tb_frame_duty_ratio_modulator
bind fdm_modulator fdm_checker u_fdm_checker (.*);
`default_nettype wire
